// ---- verilog/ufc_regs.sv ----
// Unknown-frame forward control registers, drive strength and self filter
//
// Notes on behaviour
// [RULE_01] Drive code 00=4mA, 01=8mA, 10=10mA, 11=14mA; nominal 01.
// [RULE_02] At reset drive upper bit is inverted strap, lower bit equals strap.
// [RULE_03] Strap low gives 10mA, high gives 8mA; pull-up means 8mA unconnected.
// [RULE_04] Register 0x84 bit 5 enables unknown non-IP multicast forwarding; resets 0.
// [RULE_05] Register 0x84 bits 4:0 are the non-IP multicast port map; resets zero.
// [RULE_06] Register 0x85 bit 5 enables unknown VLAN identifier forwarding; resets 0.
// [RULE_07] Register 0x85 bits 4:0 map unknown VLAN frames; bit0 is port 1.
// [RULE_08] Register 0x86 bit 6 drops self-address frames at egress; resets 0.
// [RULE_09] Self-address filtering compares against self MAC address held elsewhere.
// [RULE_10] Register 0x86 bit 5 enables unknown IP multicast forwarding; resets 0.
// [RULE_11] Register 0x86 bits 4:0 map unknown IP multicast frames; resets zero.
// [RULE_12] Reserved bits read reset values and ignore writes.
// [RULE_13] With a class enable clear, its map is ignored; ordinary handling applies.
`timescale 1ns/1ps
module ufc_regs (
   input  wire logic                 sys_clk,          // Switch core clock
   input  wire logic                 rst,              // Synchronous reset, active high
   input  wire logic                 ce,               // Clock enable, freezes state when low
   input  wire logic                 drive_strength_strap_pin, // Asynchronous strap pin level
   input  wire logic [7:0]           reg_addr,         // Register address
   input  wire logic                 reg_wr,           // Write strobe
   input  wire logic [7:0]           reg_wdata,        // Write data
   input  wire logic                 reg_rd,           // Read strobe
   output logic [7:0]                reg_rdata,        // Read data, registered
   output logic                      reg_rvalid,       // Read data valid pulse
   input  wire ufc_pkg::ufc_req_s    fwd_req,          // Unknown-destination lookup request
   output ufc_pkg::ufc_resp_s        fwd_resp,         // Lookup answer, registered
   input  wire logic                 egr_valid,        // Egress frame check request
   input  wire logic [47:0]          egr_mac,          // Frame address to check
   input  wire logic [47:0]          self_mac,         // Self MAC from address registers
   output logic                      egr_drop,         // Drop frame at egress, registered
   output logic [1:0]                pad_drive_code,   // Drive strength code, registered
   output logic [3:0]                pad_drive_ma      // Drive strength in mA
);
   // Strap synchroniser: not reset so it tracks the pin during reset
   logic strap_meta_q, strap_sync_q;
   always_ff @(posedge sys_clk) begin
      if (ce) begin
         strap_meta_q <= drive_strength_strap_pin;
         strap_sync_q <= strap_meta_q;
      end
   end

   logic [1:0] drive_q, drive_d;
   ufc_pkg::ufc_cls_cfg_s cfg_q [ufc_pkg::NUM_CLASS];
   ufc_pkg::ufc_cls_cfg_s cfg_d [ufc_pkg::NUM_CLASS];
   logic       self_en_q, self_en_d;
   logic [7:0] rdata_q, rdata_d;
   logic       rvalid_q, rvalid_d;

   function automatic logic [1:0] addr_to_cls(input logic [7:0] a);
      if (a == ufc_pkg::OFS_MCAST_CTRL) begin
         addr_to_cls = 2'h0;
      end else if (a == ufc_pkg::OFS_VLAN_CTRL) begin
         addr_to_cls = 2'h1;
      end else if (a == ufc_pkg::OFS_SELF_CTRL) begin
         addr_to_cls = 2'h2;
      end else begin
         addr_to_cls = 2'h3;
      end
   endfunction

   function automatic logic [3:0] code_to_ma(input logic [1:0] c);
      case (c)
         2'h0:    code_to_ma = ufc_pkg::MA_CODE0;
         2'h1:    code_to_ma = ufc_pkg::MA_CODE1;
         2'h2:    code_to_ma = ufc_pkg::MA_CODE2;
         default: code_to_ma = ufc_pkg::MA_CODE3;
      endcase
   endfunction

   logic [1:0] wsel, rsel;
   assign wsel = addr_to_cls(reg_addr);
   assign rsel = addr_to_cls(reg_addr);

   always_comb begin
      drive_d   = drive_q;
      self_en_d = self_en_q;
      cfg_d     = cfg_q;
      rdata_d   = rdata_q;
      rvalid_d  = 1'b0;
      if (rst) begin
         // Strap taken every reset cycle; hold reset past the synchroniser delay
         drive_d   = {~strap_sync_q, strap_sync_q};                     // [RULE_02] [RULE_03]
         self_en_d = ufc_pkg::EN_RST;                                   // [RULE_08]
         for (int i = 0; i < ufc_pkg::NUM_CLASS; i++) begin
            cfg_d[i].en  = ufc_pkg::EN_RST;                             // [RULE_04] [RULE_06] [RULE_10]
            cfg_d[i].map = ufc_pkg::MAP_RST;                            // [RULE_05] [RULE_07] [RULE_11]
         end
         rdata_d = 8'h00;
      end else begin
         if (reg_wr && wsel != 2'h3) begin
            cfg_d[wsel].en  = reg_wdata[ufc_pkg::FWD_EN_BIT];
            cfg_d[wsel].map = reg_wdata[ufc_pkg::MAP_LSB +: ufc_pkg::MAP_W];
            if (wsel == 2'h0) begin
               drive_d = reg_wdata[ufc_pkg::DRIVE_LSB +: 2];            // [RULE_01]
            end else if (wsel == 2'h2) begin
               self_en_d = reg_wdata[ufc_pkg::SELF_EN_BIT];             // [RULE_08]
            end
         end
         if (reg_rd) begin
            rvalid_d = 1'b1;
            if (rsel == 2'h0) begin
               rdata_d = {drive_q, cfg_q[0].en, cfg_q[0].map};
            end else if (rsel == 2'h1) begin
               rdata_d = {ufc_pkg::RSVD_VLAN_RST, cfg_q[1].en, cfg_q[1].map}; // [RULE_12]
            end else if (rsel == 2'h2) begin
               rdata_d = {ufc_pkg::RSVD_SELF_RST, self_en_q, cfg_q[2].en, cfg_q[2].map}; // [RULE_12]
            end else begin
               rdata_d = 8'h00;
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (ce) begin
         drive_q   <= drive_d;
         self_en_q <= self_en_d;
         cfg_q     <= cfg_d;
         rdata_q   <= rdata_d;
         rvalid_q  <= rvalid_d;
      end
   end

   // One resolver per class, selected by request class
   logic [4:0] cls_map [ufc_pkg::NUM_CLASS];
   logic       cls_forced [ufc_pkg::NUM_CLASS];
   genvar g;
   generate
      for (g = 0; g < ufc_pkg::NUM_CLASS; g++) begin : g_cls
         ufc_map_select u_sel (
            .cfg      (cfg_q[g]),
            .dflt_map (fwd_req.dflt_map),
            .out_map  (cls_map[g]),
            .forced   (cls_forced[g])
         );
      end
   endgenerate

   ufc_pkg::ufc_resp_s resp_q, resp_d;
   logic               drop_q, drop_d;
   always_comb begin
      resp_d = '0;
      drop_d = 1'b0;
      if (!rst) begin
         if (fwd_req.valid) begin
            resp_d.valid = 1'b1;
            case (fwd_req.cls)
               ufc_pkg::UFC_CLS_MCAST: begin
                  resp_d.map    = cls_map[0];                           // [RULE_05]
                  resp_d.forced = cls_forced[0];                        // [RULE_04]
               end
               ufc_pkg::UFC_CLS_VLAN: begin
                  resp_d.map    = cls_map[1];                           // [RULE_07]
                  resp_d.forced = cls_forced[1];                        // [RULE_06]
               end
               ufc_pkg::UFC_CLS_IPMC: begin
                  resp_d.map    = cls_map[2];                           // [RULE_11]
                  resp_d.forced = cls_forced[2];                        // [RULE_10]
               end
               default: begin
                  resp_d.map = fwd_req.dflt_map;                        // [RULE_13]
               end
            endcase
         end
         drop_d = egr_valid && self_en_q && (egr_mac == self_mac);      // [RULE_08] [RULE_09]
      end
   end

   always_ff @(posedge sys_clk) begin
      if (ce) begin
         resp_q <= resp_d;
         drop_q <= drop_d;
      end
   end

   assign reg_rdata      = rdata_q;
   assign reg_rvalid     = rvalid_q;
   assign fwd_resp       = resp_q;
   assign egr_drop       = drop_q;
   assign pad_drive_code = drive_q;
   assign pad_drive_ma   = code_to_ma(drive_q);                         // [RULE_01]

   // Checked only after two reset cycles: the unreset synchroniser is unknown at power-up
   chk_strap_load_bits: assert property (@(posedge sys_clk) // [RULE_02]
      (rst && ce && $past(rst && ce) && $past(rst && ce, 2))
      |=> (drive_q == {~$past(strap_sync_q), $past(strap_sync_q)}))
      else $error("drive code not loaded from strap");
   chk_strap_high_8ma: assert property (@(posedge sys_clk) // [RULE_03]
      (rst && ce && strap_sync_q) |=> (pad_drive_ma == ufc_pkg::MA_CODE1))
      else $error("strap high did not give 8 mA");
   chk_drive_ma_map: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_01]
      (pad_drive_code == 2'h2) |-> (pad_drive_ma == ufc_pkg::MA_CODE2))
      else $error("drive code 10 not 10 mA");
   chk_mcast_reset_zero: assert property (@(posedge sys_clk) // [RULE_04]
      (rst && ce) |=> (cfg_q[0].en == 1'b0 && cfg_q[0].map == 5'h00))
      else $error("multicast control not cleared at reset");
   chk_vlan_map_apply: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_07]
      (ce && fwd_req.valid && fwd_req.cls == ufc_pkg::UFC_CLS_VLAN && cfg_q[1].en)
      |=> (fwd_resp.valid && fwd_resp.forced && fwd_resp.map == $past(cfg_q[1].map)))
      else $error("vlan map not applied");
   chk_ipmc_disabled: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_13]
      (ce && fwd_req.valid && fwd_req.cls == ufc_pkg::UFC_CLS_IPMC && !cfg_q[2].en)
      |=> (!fwd_resp.forced && fwd_resp.map == $past(fwd_req.dflt_map)))
      else $error("disabled class map took effect");
   chk_self_drop: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_08]
      (ce && egr_valid && egr_mac == self_mac) |=> (egr_drop == $past(self_en_q)))
      else $error("self address drop wrong");
   chk_rsvd_read: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_12]
      (ce && reg_rd && reg_addr == ufc_pkg::OFS_SELF_CTRL) |=> (reg_rvalid && reg_rdata[7] == 1'b0))
      else $error("reserved bit read nonzero");
   chk_write_enable: assert property (@(posedge sys_clk) disable iff (rst) // [RULE_10]
      (ce && reg_wr && reg_addr == ufc_pkg::OFS_SELF_CTRL) |=> (cfg_q[2].en == $past(reg_wdata[5])))
      else $error("ip multicast enable write lost");
endmodule // ufc_regs

// ---- verilog/ufc_pkg.sv ----
// Package for the unknown-frame forward control register bank
package ufc_pkg;
   localparam logic [7:0] OFS_MCAST_CTRL = 8'h84;
   localparam logic [7:0] OFS_VLAN_CTRL  = 8'h85;
   localparam logic [7:0] OFS_SELF_CTRL  = 8'h86;
   localparam int         MAP_LSB        = 0;
   localparam int         MAP_W          = 5;
   localparam int         FWD_EN_BIT     = 5;
   localparam int         SELF_EN_BIT    = 6;
   localparam int         DRIVE_LSB      = 6;
   localparam logic [1:0] DRIVE_NOMINAL  = 2'h1;
   localparam logic [4:0] MAP_RST        = 5'h00;
   localparam logic       EN_RST         = 1'b0;
   localparam logic [1:0] RSVD_VLAN_RST  = 2'h0;
   localparam logic       RSVD_SELF_RST  = 1'b0;
   localparam logic [3:0] MA_CODE0       = 4'h4;
   localparam logic [3:0] MA_CODE1       = 4'h8;
   localparam logic [3:0] MA_CODE2       = 4'hA;
   localparam logic [3:0] MA_CODE3       = 4'hE;
   localparam int         NUM_CLASS      = 3;

   typedef enum logic [2:0] {
      UFC_CLS_MCAST = 3'b001,
      UFC_CLS_VLAN  = 3'b010,
      UFC_CLS_IPMC  = 3'b100
   } ufc_class_e;

   typedef struct packed {
      logic       valid;
      ufc_class_e cls;
      logic [4:0] dflt_map;
   } ufc_req_s;

   typedef struct packed {
      logic       valid;
      logic       forced;
      logic [4:0] map;
   } ufc_resp_s;

   typedef struct packed {
      logic       en;
      logic [4:0] map;
   } ufc_cls_cfg_s;
endpackage

// ---- verilog/ufc_map_select.sv ----
// Per-class egress map choice between programmed map and ordinary handling
`timescale 1ns/1ps
module ufc_map_select (
   input  wire ufc_pkg::ufc_cls_cfg_s cfg,       // Class enable and port map
   input  wire logic [4:0]            dflt_map,  // Ordinary unknown handling map
   output logic [4:0]                 out_map,   // Resulting egress map
   output logic                       forced     // Programmed map applied
);
   // Zero map filters, ones broadcasts, else per-port pick
   always_comb begin
      forced  = cfg.en;                          // [RULE_13]
      out_map = cfg.en ? cfg.map : dflt_map;     // [RULE_05] [RULE_07] [RULE_11] [RULE_13]
   end
endmodule // ufc_map_select

// ---- tb/tb_ufc_regs.sv ----
// Self-checking bench for the unknown-frame forward control registers
`timescale 1ns/1ps
module tb_ufc_regs;
   logic               sys_clk = 1'b0;
   logic               rst = 1'b1;
   logic               ce = 1'b1;
   logic               drive_strength_strap_pin = 1'b1;
   logic [7:0]         reg_addr = 8'h00;
   logic               reg_wr = 1'b0;
   logic [7:0]         reg_wdata = 8'h00;
   logic               reg_rd = 1'b0;
   logic [7:0]         reg_rdata;
   logic               reg_rvalid;
   ufc_pkg::ufc_req_s  fwd_req = '0;
   ufc_pkg::ufc_resp_s fwd_resp;
   logic               egr_valid = 1'b0;
   logic [47:0]        egr_mac = 48'h000000000000;
   logic [47:0]        self_mac = 48'h0A1B2C3D4E5F;
   logic               egr_drop;
   logic [1:0]         pad_drive_code;
   logic [3:0]         pad_drive_ma;
   logic [7:0]         ma_tab [4] = '{8'h04, 8'h08, 8'h0A, 8'h0E};
   int                 fail_count = 0;
   int                 comparisons = 0;
   int                 cycles = 0;

   ufc_regs u_dut (
      .sys_clk                  (sys_clk),
      .rst                      (rst),
      .ce                       (ce),
      .drive_strength_strap_pin (drive_strength_strap_pin),
      .reg_addr                 (reg_addr),
      .reg_wr                   (reg_wr),
      .reg_wdata                (reg_wdata),
      .reg_rd                   (reg_rd),
      .reg_rdata                (reg_rdata),
      .reg_rvalid               (reg_rvalid),
      .fwd_req                  (fwd_req),
      .fwd_resp                 (fwd_resp),
      .egr_valid                (egr_valid),
      .egr_mac                  (egr_mac),
      .self_mac                 (self_mac),
      .egr_drop                 (egr_drop),
      .pad_drive_code           (pad_drive_code),
      .pad_drive_ma             (pad_drive_ma)
   );

   initial begin
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Cut a hang short well beyond the roughly 80 cycles the tests need
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         $display("Error at %0t: run did not finish in time", $time);
         print_verdict();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Strap held through all reset cycles so the synchroniser settles
   task automatic do_reset(input logic strap);
      @(negedge sys_clk);
      drive_strength_strap_pin = strap;
      rst = 1'b1;
      repeat (5) @(negedge sys_clk);
      rst = 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge sys_clk);
      reg_wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge sys_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      chk({7'h00, reg_rvalid}, 8'h01, "read valid");
      chk(reg_rdata, exp, "read data");
   endtask

   task automatic lookup(input ufc_pkg::ufc_class_e c, input logic f, input logic [4:0] m);
      @(negedge sys_clk);
      fwd_req = '{valid: 1'b1, cls: c, dflt_map: 5'h0A};
      @(negedge sys_clk);
      fwd_req = '0;
      chk({1'b0, fwd_resp}, {2'h1, f, m}, "lookup answer");
   endtask

   task automatic egr(input logic [47:0] mac, input logic exp);
      @(negedge sys_clk);
      egr_valid = 1'b1;
      egr_mac = mac;
      @(negedge sys_clk);
      egr_valid = 1'b0;
      chk({7'h00, egr_drop}, {7'h00, exp}, "egress drop");
   endtask

   initial begin
      do_reset(1'b1);
      rd(ufc_pkg::OFS_MCAST_CTRL, 8'h40);
      chk({4'h0, pad_drive_ma}, 8'h08, "drive mA strap high");
      rd(ufc_pkg::OFS_VLAN_CTRL, 8'h00);
      rd(ufc_pkg::OFS_SELF_CTRL, 8'h00);
      do_reset(1'b0);
      rd(ufc_pkg::OFS_MCAST_CTRL, 8'h80);
      chk({4'h0, pad_drive_ma}, 8'h0A, "drive mA strap low");
      $display("Test reset values done");
      for (int i = 0; i < 4; i++) begin
         wr(ufc_pkg::OFS_MCAST_CTRL, {i[1:0], 6'h00});
         chk({4'h0, pad_drive_ma}, ma_tab[i], "drive mA decode");
         chk({6'h00, pad_drive_code}, {6'h00, i[1:0]}, "drive code");
      end
      wr(ufc_pkg::OFS_VLAN_CTRL, 8'hFF);
      rd(ufc_pkg::OFS_VLAN_CTRL, 8'h3F);
      wr(ufc_pkg::OFS_SELF_CTRL, 8'hFF);
      rd(ufc_pkg::OFS_SELF_CTRL, 8'h7F);
      wr(8'h87, 8'hFF);
      rd(8'h87, 8'h00);
      $display("Test register access done");
      wr(ufc_pkg::OFS_MCAST_CTRL, 8'h55);
      wr(ufc_pkg::OFS_VLAN_CTRL, 8'h01);
      wr(ufc_pkg::OFS_SELF_CTRL, 8'h1F);
      lookup(ufc_pkg::UFC_CLS_MCAST, 1'b0, 5'h0A);
      lookup(ufc_pkg::UFC_CLS_VLAN, 1'b0, 5'h0A);
      lookup(ufc_pkg::UFC_CLS_IPMC, 1'b0, 5'h0A);
      egr(self_mac, 1'b0);
      wr(ufc_pkg::OFS_MCAST_CTRL, 8'h75);
      wr(ufc_pkg::OFS_VLAN_CTRL, 8'h21);
      wr(ufc_pkg::OFS_SELF_CTRL, 8'h7F);
      lookup(ufc_pkg::UFC_CLS_MCAST, 1'b1, 5'h15);
      lookup(ufc_pkg::UFC_CLS_VLAN, 1'b1, 5'h01);
      lookup(ufc_pkg::UFC_CLS_IPMC, 1'b1, 5'h1F);
      lookup(ufc_pkg::ufc_class_e'(3'b011), 1'b0, 5'h0A);
      $display("Test forward lookup done");
      egr(self_mac, 1'b1);
      egr(48'h0A1B2C3D4E5E, 1'b0);
      wr(ufc_pkg::OFS_SELF_CTRL, 8'h3F);
      egr(self_mac, 1'b0);
      $display("Test self filter done");
      // Write while frozen must not land
      ce = 1'b0;
      wr(ufc_pkg::OFS_VLAN_CTRL, 8'h00);
      ce = 1'b1;
      rd(ufc_pkg::OFS_VLAN_CTRL, 8'h21);
      $display("Test clock enable done");
      print_verdict();
   end
endmodule // tb_ufc_regs
